// ### slrx_pkg.sv
// Shared constants and types for the serial link receiver configuration block
package slrx_pkg;
  // Register addresses on the device register port
  localparam logic [11:0] ADDR_CHECK = 12'h030;
  localparam logic [11:0] ADDR_SYNC_PWR = 12'h203;
  localparam logic [11:0] ADDR_LINK_CTRL = 12'h300;
  localparam logic [11:0] ADDR_MFC_DELAY = 12'h0A0;
  localparam logic [11:0] ADDR_LANES = 12'h453;
  localparam logic [11:0] ADDR_OCT_M1 = 12'h454;
  localparam logic [11:0] ADDR_KFRM = 12'h455;
  localparam logic [11:0] ADDR_CONV = 12'h456;
  localparam logic [11:0] ADDR_RES = 12'h457;
  localparam logic [11:0] ADDR_PACK = 12'h458;
  localparam logic [11:0] ADDR_VER = 12'h459;
  localparam logic [11:0] ADDR_DENS = 12'h45A;
  localparam logic [11:0] ADDR_DESKEW = 12'h46C;
  localparam logic [11:0] ADDR_OCT = 12'h476;
  localparam logic [11:0] ADDR_LANE_EN = 12'h47D;
  // Bit positions
  localparam int BIT_DUAL = 3;
  localparam int BIT_MAPSEL = 2;
  localparam int BIT_SYNC1_PD = 0;
  localparam int BIT_SCRAMBLE = 7;
  localparam int CHK_DELAY = 5;
  localparam int CHK_MODE = 3;
  localparam int CHK_K = 2;
  localparam int CHK_SUBCLASS = 1;
  // Field values
  localparam logic [4:0] K_FIELD_16 = 5'h0F;
  localparam logic [4:0] K_FIELD_32 = 5'h1F;
  localparam logic [2:0] SUBCLASS_MAX = 3'h1;
  localparam logic [2:0] VERSION_B = 3'h1;
  localparam logic [7:0] RES_16BIT = 8'h0F;
  localparam logic [4:0] PACK_16BIT = 5'h0F;
  localparam logic [7:0] DENS_HD = 8'h80;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_ONE = 8'h01;
  localparam logic [7:0] LANE_MASK_ALL = 8'hFF;
  localparam logic [2:0] LANE_IDX_MAX = 3'h7;
  // Mode table: index is the mode number, ok bit clear for unsupported mode 8
  typedef struct packed {
    logic ok;
    logic [1:0] m1;
    logic [2:0] l1;
    logic s1;
    logic [1:0] f1;
  } slrx_mode_t;
  localparam int MODE_LAST = 10;
  localparam int DUAL_FIRST = 4;
  localparam slrx_mode_t MODE_TABLE [0:10] = '{
    '{1'h1, 2'h3, 3'h7, 1'h0, 2'h0}, '{1'h1, 2'h3, 3'h7, 1'h1, 2'h1},
    '{1'h1, 2'h3, 3'h3, 1'h0, 2'h1}, '{1'h1, 2'h3, 3'h1, 1'h0, 2'h3},
    '{1'h1, 2'h1, 3'h3, 1'h0, 2'h0}, '{1'h1, 2'h1, 3'h3, 1'h1, 2'h1},
    '{1'h1, 2'h1, 3'h1, 1'h0, 2'h1}, '{1'h1, 2'h1, 3'h0, 1'h0, 2'h3},
    '{1'h0, 2'h0, 3'h0, 1'h0, 2'h0}, '{1'h1, 2'h0, 3'h1, 1'h0, 2'h0},
    '{1'h1, 2'h0, 3'h0, 1'h0, 2'h1}};
  // One link's parameter map
  typedef struct packed {
    logic [7:0] lanes;
    logic [7:0] oct_m1;
    logic [7:0] kfrm;
    logic [7:0] conv;
    logic [7:0] res;
    logic [7:0] pack;
    logic [7:0] ver;
    logic [7:0] dens;
    logic [7:0] deskew;
    logic [7:0] oct;
    logic [7:0] lane_en;
  } slrx_map_t;
  // Host sequencer write order per link
  localparam int STEP_LAST = 12;
  localparam logic [11:0] HOST_SEQ [0:12] = '{
    ADDR_LINK_CTRL, ADDR_SYNC_PWR, ADDR_LANES, ADDR_OCT_M1, ADDR_KFRM,
    ADDR_CONV, ADDR_RES, ADDR_PACK, ADDR_VER, ADDR_DENS, ADDR_OCT,
    ADDR_DESKEW, ADDR_LANE_EN};
  // Host command port addresses and control fields
  localparam logic [1:0] CMD_CTRL = 2'h0;
  localparam logic [1:0] CMD_STATUS = 2'h1;
  localparam logic [1:0] CMD_RESULT = 2'h2;
  localparam logic [1:0] CMD_START = 2'h3;
  localparam int CTL_DUAL = 4;
  localparam int CTL_SCRAMBLE = 5;
  localparam int CTL_SUBCLASS1 = 6;
  localparam int CTL_K16 = 7;
endpackage

// ### slrx_if.sv
// Register port between the configuring host and the receiver
`timescale 1ns/1ps
interface slrx_if;
  logic [11:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  modport dev (input addr, input wdata, input wr, input rd, output rdata);
  modport host (output addr, output wdata, output wr, output rd, input rdata);
endinterface

// ### slrx_rx_cfg.sv
// Receiver end: link parameter registers, map steering and configuration checks
//
// Summary of operation
// - Single link all modes, dual from four
// - Link control bit 3 selects dual link
// - Host programs second link identical in dual
// - Link control bit 2 steers to second map
// - Buffer control bit 0 powers down sync
// - Check bit 5: illegal multiframe clock delay
// - Check bit 3: unsupported lane/converter/octet/sample combination
// - Check bit 2: illegal frames per multiframe
// - Check bit 1: illegal subclass version
// - Deskew bit per logical lane
// - Enable bit per logical lane
// - Host: parameters, then deskew, then enables
// - Lane register: descramble bit, lanes minus one
// - Host writes both octet fields consistently
// - Host writes 16 or 32 frame codes
// - Converter register holds converters minus one
// - Host keeps control bits zero, 16-bit
// - Packing register: subclass and bits per sample
// - Version register: revision and samples minus one
// - Host sets high density for one octet
// - Eight lanes: deskew and enable all
// - Four lanes: deskew and enable low four
`timescale 1ns/1ps
module slrx_rx_cfg
  import slrx_pkg::*;
(
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic NRST_IN,
  // Register port
  slrx_if.dev bus,
  // Link control state
  output logic TWO_LINK_SELECT_OUT,
  output logic SYNC1_BUF_EN_OUT,
  output logic [1:0] DESCRAMBLE_OUT,
  output logic [7:0] MULTIFRAME_CLOCK_DELAY_OUT,
  // Per lane selects, link 0 then link 1
  output logic [7:0] LANE_DESKEW0_OUT,
  output logic [7:0] LANE_DESKEW1_OUT,
  output logic [7:0] LANE_ENABLE0_OUT,
  output logic [7:0] LANE_ENABLE1_OUT,
  // Check result
  output logic [7:0] CHECK_STATUS_OUT
);

  // Whole state of the receiver end
  typedef struct packed {
    // Link wide controls
    logic [7:0] sync_pwr;
    logic sync_en;
    logic [7:0] link_ctrl;
    logic [7:0] multiframe_clock_delay;
    // Parameter maps, link 0 then link 1
    slrx_map_t [1:0] map;
    // Check result and read data
    logic [7:0] check;
    logic [7:0] rdata;
  } slrx_dev_state_t;

  slrx_dev_state_t q;
  slrx_dev_state_t next_q;
  logic sel;
  // Mode matches per table entry, and check result per map
  logic [MODE_LAST:0] hit0;
  logic [MODE_LAST:0] hit1;
  logic [7:0] chk0;
  logic [7:0] chk1;

  // Match of one link map against one mode table entry
  function automatic logic slrx_hit(input slrx_map_t m, input slrx_mode_t e);
    return e.ok
           && m.conv == 8'(e.m1)
           && m.lanes[4:0] == 5'(e.l1)
           && m.ver[4:0] == 5'(e.s1)
           && m.oct_m1 == 8'(e.f1)
           // Octet count is held twice and both copies must agree
           && m.oct == m.oct_m1 + BYTE_ONE;
  endfunction

  // Configuration check on one link map, given its mode match
  function automatic logic [7:0] slrx_check(input slrx_map_t m, input logic found,
                                            input logic [7:0] dly);
    logic [7:0] r;
    logic [2:0] subclass_version_field;
    r = BYTE_ZERO;
    subclass_version_field = m.pack[7:5];
    r[CHK_MODE] = !found;
    // Single octet modes only permit 32 frames
    if ((m.kfrm[4:0] != K_FIELD_16 && m.kfrm[4:0] != K_FIELD_32)
        || (m.oct_m1 == BYTE_ZERO && m.kfrm[4:0] != K_FIELD_32))
    begin
      r[CHK_K] = 1'b1;
    end
    // Only subclass 0 and subclass 1 exist
    r[CHK_SUBCLASS] = subclass_version_field > SUBCLASS_MAX;
    // Delay must land inside the multiframe
    r[CHK_DELAY] = dly > {3'h0, m.kfrm[4:0]};
    return r;
  endfunction

  // One comparator per mode table entry and map; dual link only from mode four
  // Link 1 map is only ever judged as a dual link map
  for (genvar i = 0; i <= MODE_LAST; i++)
  begin : g_mode
    assign hit0[i] = slrx_hit(q.map[0], MODE_TABLE[i])
                     && (!q.link_ctrl[BIT_DUAL] || i >= DUAL_FIRST);
    assign hit1[i] = slrx_hit(q.map[1], MODE_TABLE[i]) && i >= DUAL_FIRST;
  end

  // Check of each map
  assign chk0 = slrx_check(q.map[0], |hit0, q.multiframe_clock_delay);
  assign chk1 = slrx_check(q.map[1], |hit1, q.multiframe_clock_delay);

  // Parameter map chosen for host access; a new select bit steers
  // only the writes after the one that sets it
  assign sel = q.link_ctrl[BIT_MAPSEL];

  // Next state: register writes, reads and checks
  always_comb
  begin
    next_q = q;
    // Read data stands one cycle only
    next_q.rdata = BYTE_ZERO;
    // Re-evaluated every cycle, so status lags a write by one cycle;
    // in dual link mode a fault in either map shows
    next_q.check = q.link_ctrl[BIT_DUAL] ? (chk0 | chk1) : chk0;
    // Register writes; status and unmapped addresses ignore them
    if (bus.wr)
    begin
      unique case (bus.addr)
        ADDR_CHECK: next_q.rdata = BYTE_ZERO;
        ADDR_SYNC_PWR: next_q.sync_pwr = bus.wdata;
        ADDR_LINK_CTRL: next_q.link_ctrl = bus.wdata;
        ADDR_MFC_DELAY: next_q.multiframe_clock_delay = bus.wdata;
        ADDR_LANES: next_q.map[sel].lanes = bus.wdata;
        ADDR_OCT_M1: next_q.map[sel].oct_m1 = bus.wdata;
        ADDR_KFRM: next_q.map[sel].kfrm = bus.wdata;
        ADDR_CONV: next_q.map[sel].conv = bus.wdata;
        ADDR_RES: next_q.map[sel].res = bus.wdata;
        ADDR_PACK: next_q.map[sel].pack = bus.wdata;
        ADDR_VER: next_q.map[sel].ver = bus.wdata;
        ADDR_DENS: next_q.map[sel].dens = bus.wdata;
        ADDR_DESKEW: next_q.map[sel].deskew = bus.wdata;
        ADDR_OCT: next_q.map[sel].oct = bus.wdata;
        ADDR_LANE_EN: next_q.map[sel].lane_en = bus.wdata;
        default: next_q.rdata = BYTE_ZERO;
      endcase
    end
    // Buffer enable kept in its own flop so the pin needs no gate
    next_q.sync_en = !next_q.sync_pwr[BIT_SYNC1_PD];
    // Read data for the cycle after the strobe
    if (bus.rd)
    begin
      unique case (bus.addr)
        ADDR_CHECK: next_q.rdata = q.check;
        ADDR_SYNC_PWR: next_q.rdata = q.sync_pwr;
        ADDR_LINK_CTRL: next_q.rdata = q.link_ctrl;
        ADDR_MFC_DELAY: next_q.rdata = q.multiframe_clock_delay;
        ADDR_LANES: next_q.rdata = q.map[sel].lanes;
        ADDR_OCT_M1: next_q.rdata = q.map[sel].oct_m1;
        ADDR_KFRM: next_q.rdata = q.map[sel].kfrm;
        ADDR_CONV: next_q.rdata = q.map[sel].conv;
        ADDR_RES: next_q.rdata = q.map[sel].res;
        ADDR_PACK: next_q.rdata = q.map[sel].pack;
        ADDR_VER: next_q.rdata = q.map[sel].ver;
        ADDR_DENS: next_q.rdata = q.map[sel].dens;
        ADDR_DESKEW: next_q.rdata = q.map[sel].deskew;
        ADDR_OCT: next_q.rdata = q.map[sel].oct;
        ADDR_LANE_EN: next_q.rdata = q.map[sel].lane_en;
        default: next_q.rdata = BYTE_ZERO;
      endcase
    end
  end

  // State register; asynchronous clear to zero,
  // except the sync buffer enable
  always_ff @(posedge CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
    begin
      q <= '0;
      q.sync_en <= 1'b1;
    end
    else
    begin
      q <= next_q;
    end
  end

  // Outputs straight from the state register
  assign bus.rdata = q.rdata;
  assign TWO_LINK_SELECT_OUT = q.link_ctrl[BIT_DUAL];
  assign SYNC1_BUF_EN_OUT = q.sync_en;
  assign DESCRAMBLE_OUT = {q.map[1].lanes[BIT_SCRAMBLE],
                           q.map[0].lanes[BIT_SCRAMBLE]};
  assign MULTIFRAME_CLOCK_DELAY_OUT = q.multiframe_clock_delay;
  // Per lane selects, link 0 then link 1
  assign LANE_DESKEW0_OUT = q.map[0].deskew;
  assign LANE_DESKEW1_OUT = q.map[1].deskew;
  assign LANE_ENABLE0_OUT = q.map[0].lane_en;
  assign LANE_ENABLE1_OUT = q.map[1].lane_en;
  // Check status mirrors its register
  assign CHECK_STATUS_OUT = q.check;

endmodule

// ### slrx_host_cfg.sv
// Transmitter end: sequencer that programs a chosen mode into the receiver
`timescale 1ns/1ps
module slrx_host_cfg
  import slrx_pkg::*;
(
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic NRST_IN,
  // Command port
  input wire logic [1:0] CMD_ADDR_IN,
  input wire logic [7:0] CMD_WDATA_IN,
  input wire logic CMD_WR_IN,
  input wire logic CMD_RD_IN,
  output logic [7:0] CMD_RDATA_OUT,
  // Receiver register port
  slrx_if.host bus
);

  typedef enum logic [1:0] {ST_IDLE, ST_WRITE, ST_WAIT, ST_CAPTURE} slrx_phase_t;

  typedef struct packed {
    slrx_phase_t phase;
    logic [7:0] ctrl;
    logic busy;
    logic done;
    logic refused;
    logic [7:0] result;
    logic link;
    logic [3:0] step;
    logic [11:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic [7:0] rdata;
  } slrx_host_state_t;

  slrx_host_state_t q;
  slrx_host_state_t next_q;
  slrx_mode_t md;
  logic dual;
  logic [7:0] val;

  assign md = MODE_TABLE[q.ctrl[3:0] > 4'(MODE_LAST) ? 4'h8 : q.ctrl[3:0]];
  assign dual = q.ctrl[CTL_DUAL];

  // Value for the current step; link 1 gets the same parameters
  always_comb
  begin
    unique case (HOST_SEQ[q.step])
      ADDR_LINK_CTRL: val = 8'({dual, q.link, 2'h0});
      ADDR_SYNC_PWR: val = 8'(!dual);
      ADDR_LANES: val = {q.ctrl[CTL_SCRAMBLE], 2'h0, 5'(md.l1)};
      ADDR_OCT_M1: val = 8'(md.f1);
      ADDR_KFRM: val = 8'((md.f1 == 2'h0 || !q.ctrl[CTL_K16]) ? K_FIELD_32
                          : K_FIELD_16);
      ADDR_CONV: val = 8'(md.m1);
      ADDR_RES: val = RES_16BIT;
      ADDR_PACK: val = {q.ctrl[CTL_SUBCLASS1] ? SUBCLASS_MAX : 3'h0, PACK_16BIT};
      ADDR_VER: val = {VERSION_B, 4'h0, md.s1};
      ADDR_DENS: val = (md.f1 == 2'h0) ? DENS_HD : BYTE_ZERO;
      ADDR_OCT: val = 8'(md.f1) + BYTE_ONE;
      default: val = LANE_MASK_ALL >> (LANE_IDX_MAX - md.l1);
    endcase
  end

  // Sequencer and command registers
  always_comb
  begin
    next_q = q;
    next_q.wr = 1'b0;
    next_q.rd = 1'b0;
    next_q.rdata = BYTE_ZERO;
    if (CMD_RD_IN)
    begin
      unique case (CMD_ADDR_IN)
        CMD_CTRL: next_q.rdata = q.ctrl;
        CMD_STATUS: next_q.rdata = 8'({q.refused, q.done, q.busy});
        CMD_RESULT: next_q.rdata = q.result;
        CMD_START: next_q.rdata = BYTE_ZERO;
      endcase
    end
    if (CMD_WR_IN && !q.busy && CMD_ADDR_IN == CMD_CTRL)
    begin
      next_q.ctrl = CMD_WDATA_IN;
    end
    unique case (q.phase)
      ST_IDLE:
      begin
        if (CMD_WR_IN && CMD_ADDR_IN == CMD_START)
        begin
          next_q.done = 1'b0;
          // Unknown mode, or a single-link-only mode asked for dual
          if (!md.ok || (dual && q.ctrl[3:0] < 4'(DUAL_FIRST)))
          begin
            next_q.refused = 1'b1;
          end
          else
          begin
            next_q.refused = 1'b0;
            next_q.busy = 1'b1;
            next_q.link = 1'b0;
            next_q.step = 4'h0;
            next_q.phase = ST_WRITE;
          end
        end
      end
      ST_WRITE:
      begin
        // Parameters, then deskew, then enables, per link
        next_q.wr = 1'b1;
        next_q.addr = HOST_SEQ[q.step];
        next_q.wdata = val;
        next_q.step = q.step + 4'h1;
        if (q.step == 4'(STEP_LAST))
        begin
          next_q.step = 4'h0;
          if (dual && !q.link)
          begin
            next_q.link = 1'b1;
          end
          else
          begin
            next_q.phase = ST_WAIT;
          end
        end
      end
      ST_WAIT:
      begin
        next_q.rd = 1'b1;
        next_q.addr = ADDR_CHECK;
        next_q.phase = ST_CAPTURE;
      end
      ST_CAPTURE:
      begin
        // Data returns the cycle after the read strobe
        if (!q.rd)
        begin
          next_q.result = bus.rdata;
          next_q.busy = 1'b0;
          next_q.done = 1'b1;
          next_q.phase = ST_IDLE;
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
    begin
      q <= '0;
    end
    else
    begin
      q <= next_q;
    end
  end

  // Outputs from the state register
  assign bus.addr = q.addr;
  assign bus.wdata = q.wdata;
  assign bus.wr = q.wr;
  assign bus.rd = q.rd;
  assign CMD_RDATA_OUT = q.rdata;

endmodule

// ### slrx_asserts.sv
// Protocol checks on the register port between host sequencer and receiver
`timescale 1ns/1ps
module slrx_asserts
  import slrx_pkg::*;
(
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic NRST_IN,
  // Register port signals
  input wire logic [11:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata
);
  logic [7:0] last_ctrl;
  logic [7:0] last_lanes;
  logic [7:0] last_oct_m1;
  logic [7:0] last_desk;
  logic [8:0] lane_mask;

  // Remember earlier fields of the current programming pass
  always_ff @(posedge CLK_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
    begin
      last_ctrl <= BYTE_ZERO;
      last_lanes <= BYTE_ZERO;
      last_oct_m1 <= BYTE_ZERO;
      last_desk <= BYTE_ZERO;
    end
    else if (wr)
    begin
      if (addr == ADDR_LINK_CTRL) last_ctrl <= wdata;
      if (addr == ADDR_LANES) last_lanes <= wdata;
      if (addr == ADDR_OCT_M1) last_oct_m1 <= wdata;
      if (addr == ADDR_DESKEW) last_desk <= wdata;
    end
  end

  // One bit per used lane, from the lane count field
  assign lane_mask = (9'h001 << ({1'b0, last_lanes[2:0]} + 4'h1)) - 9'h001;

  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!NRST_IN);

  sequence s_wr_to(logic [11:0] a);
    wr && addr == a;
  endsequence

  AST_NO_WR_RD: assert property (!(wr && rd))
    else $error("write and read strobes together");
  AST_RDATA_IDLE: assert property (!$past(rd) |-> rdata == BYTE_ZERO)
    else $error("read data outside its cycle");
  AST_CTRL_THEN_PWR: assert property (s_wr_to(ADDR_LINK_CTRL) |=> s_wr_to(ADDR_SYNC_PWR))
    else $error("buffer control not written after link control");
  AST_SYNC_PWR: assert property (s_wr_to(ADDR_SYNC_PWR) |-> wdata == {7'h00, !last_ctrl[BIT_DUAL]})
    else $error("sync buffer power value wrong for link mode");
  AST_OCT_PAIR: assert property (s_wr_to(ADDR_OCT) |-> wdata == last_oct_m1 + 8'h01)
    else $error("octet fields disagree");
  AST_K_CODE: assert property (s_wr_to(ADDR_KFRM) |-> wdata[4:0] == K_FIELD_32
    || (wdata[4:0] == K_FIELD_16 && last_oct_m1 != BYTE_ZERO))
    else $error("illegal frames per multiframe code");
  AST_RES: assert property (s_wr_to(ADDR_RES) |-> wdata == RES_16BIT)
    else $error("resolution value wrong");
  AST_PACK: assert property (s_wr_to(ADDR_PACK) |->
    wdata[4:0] == PACK_16BIT && wdata[7:5] <= SUBCLASS_MAX)
    else $error("packing value wrong");
  AST_VER: assert property (s_wr_to(ADDR_VER) |-> wdata[7:5] == VERSION_B)
    else $error("version field wrong");
  AST_DENS: assert property (s_wr_to(ADDR_DENS) |->
    wdata == ((last_oct_m1 == BYTE_ZERO) ? DENS_HD : BYTE_ZERO))
    else $error("density value wrong");
  AST_DESKEW_MASK: assert property (s_wr_to(ADDR_DESKEW) |-> wdata == lane_mask[7:0])
    else $error("deskew mask does not match lane count");
  AST_LANES_EIGHT: assert property (wr && addr == ADDR_DESKEW && last_lanes[4:0] == 5'h07
    |-> wdata == LANE_MASK_ALL)
    else $error("eight lane deskew mask wrong");
  AST_LANES_FOUR: assert property (wr && addr == ADDR_DESKEW && last_lanes[4:0] == 5'h03
    |-> wdata == 8'h0F)
    else $error("four lane deskew mask wrong");
  AST_DESKEW_THEN_EN: assert property (s_wr_to(ADDR_DESKEW) |=>
    wr && addr == ADDR_LANE_EN && wdata == last_desk)
    else $error("lane enable not following deskew");

  // Main scenarios
  COV_SECOND_MAP: cover property (wr && addr == ADDR_LINK_CTRL && wdata[BIT_MAPSEL]);
  COV_CHECK_READ: cover property (rd && addr == ADDR_CHECK);
  COV_EIGHT_LANES: cover property (wr && addr == ADDR_LANE_EN && wdata == LANE_MASK_ALL);
endmodule

// ### tb.sv
// Testbench: host sequencer programs the receiver across the register port
`timescale 1ns/1ps
module tb
  import slrx_pkg::*;
;
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] mask;
  } slrx_row_t;
  logic clk, rst_n, c_wr, c_rd, two_link, sync_en, dual, scr;
  logic [1:0] c_addr, descr;
  logic [7:0] c_wdata, c_rdata, mfc_dly, desk0, desk1, en0, en1, chk, st, r, wr_seen;
  int fail_count, num_checks;
  // Command byte and expected lane mask per mode
  slrx_row_t rows [0:13] = '{'{8'h00, 8'hFF}, '{8'h80, 8'hFF}, '{8'h81, 8'hFF},
    '{8'h22, 8'h0F}, '{8'h43, 8'h03}, '{8'h04, 8'h0F}, '{8'h85, 8'h0F}, '{8'h26, 8'h03},
    '{8'h47, 8'h01}, '{8'h89, 8'h03}, '{8'h2A, 8'h01}, '{8'h34, 8'h0F}, '{8'h1A, 8'h01},
    '{8'hD7, 8'h01}};
  logic [7:0] bad [0:3] = '{8'h08, 8'h0B, 8'h13, 8'h10};

  // Clock
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Both ends joined by the interface
  slrx_if u_slrx_if ();
  slrx_host_cfg u_slrx_host_cfg (.CLK_IN(clk), .NRST_IN(rst_n), .CMD_ADDR_IN(c_addr),
    .CMD_WDATA_IN(c_wdata), .CMD_WR_IN(c_wr), .CMD_RD_IN(c_rd), .CMD_RDATA_OUT(c_rdata),
    .bus(u_slrx_if.host));
  slrx_rx_cfg u_slrx_rx_cfg (.CLK_IN(clk), .NRST_IN(rst_n), .bus(u_slrx_if.dev),
    .TWO_LINK_SELECT_OUT(two_link), .SYNC1_BUF_EN_OUT(sync_en), .DESCRAMBLE_OUT(descr),
    .MULTIFRAME_CLOCK_DELAY_OUT(mfc_dly), .LANE_DESKEW0_OUT(desk0), .LANE_DESKEW1_OUT(desk1),
    .LANE_ENABLE0_OUT(en0), .LANE_ENABLE1_OUT(en1), .CHECK_STATUS_OUT(chk));
  slrx_asserts u_slrx_asserts (.CLK_IN(clk), .NRST_IN(rst_n), .addr(u_slrx_if.addr),
    .wdata(u_slrx_if.wdata), .wr(u_slrx_if.wr), .rd(u_slrx_if.rd), .rdata(u_slrx_if.rdata));

  // Count register writes crossing the port
  always @(posedge clk)
    if (!rst_n) wr_seen <= BYTE_ZERO;
    else if (u_slrx_if.wr === 1'b1) wr_seen <= wr_seen + 8'h01;

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmd_wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    c_addr <= a;
    c_wdata <= d;
    c_wr <= 1'b1;
    @(posedge clk);
    c_wr <= 1'b0;
  endtask

  // Read data stands in the cycle after the strobe
  task automatic cmd_rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk);
    c_addr <= a;
    c_rd <= 1'b1;
    @(posedge clk);
    c_rd <= 1'b0;
    #1;
    d = c_rdata;
  endtask

  task automatic results();
    $display("checks=%0d mismatches=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Watchdog
  initial
  begin
    repeat (8000) @(posedge clk);
    fail_count++;
    results();
  end

  initial
  begin
    rst_n = 1'b0;
    c_addr = 2'h0;
    c_wdata = BYTE_ZERO;
    c_wr = 1'b0;
    c_rd = 1'b0;
    fail_count = 0;
    num_checks = 0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    // First edge after release: all-zero maps are flagged
    @(posedge clk);
    #1;
    chk8(chk, 8'h0C);
    chk8({6'h00, sync_en, two_link}, 8'h02);
    // Every legal mode single link; modes 4, 7 and 10 also dual link
    foreach (rows[i])
    begin
      cmd_wr(CMD_CTRL, rows[i].ctrl);
      cmd_wr(CMD_START, BYTE_ZERO);
      st = BYTE_ZERO;
      for (int n = 0; n < 100 && st[1] !== 1'b1; n++) cmd_rd(CMD_STATUS, st);
      chk8({7'h00, st[1]}, 8'h01);
      cmd_rd(CMD_RESULT, r);
      chk8(r, BYTE_ZERO);
      dual = rows[i].ctrl[CTL_DUAL];
      scr = rows[i].ctrl[CTL_SCRAMBLE];
      chk8({7'h00, two_link}, {7'h00, dual});
      chk8({7'h00, sync_en}, {7'h00, dual});
      chk8({7'h00, descr[0]}, {7'h00, scr});
      chk8(desk0, rows[i].mask);
      chk8(en0, rows[i].mask);
      chk8(chk, BYTE_ZERO);
      chk8(mfc_dly, BYTE_ZERO);
      if (dual)
      begin
        chk8(en1, rows[i].mask);
        chk8(desk1, rows[i].mask);
        chk8({7'h00, descr[1]}, {7'h00, scr});
      end
    end
    // Unsupported modes: refused with no port traffic
    foreach (bad[j])
    begin
      r = wr_seen;
      cmd_wr(CMD_CTRL, bad[j]);
      cmd_wr(CMD_START, BYTE_ZERO);
      repeat (20) @(posedge clk);
      cmd_rd(CMD_STATUS, st);
      chk8({7'h00, st[2]}, 8'h01);
      chk8(wr_seen, r);
    end
    chk8(en0, rows[13].mask);
    // Second reset in mid-run, asserted on a clock edge
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk8(chk, BYTE_ZERO);
    chk8({6'h00, sync_en, two_link}, 8'h02);
    chk8(en0, BYTE_ZERO);
    @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    chk8(chk, 8'h0C);
    @(posedge clk);
    #1;
    chk8(chk, 8'h0C);
    results();
  end
endmodule
